// File: src/pin_change_edge_detector.sv
`timescale 1ns/1ps
`default_nettype none
module pin_change_edge_detector #(
    parameter bit large_variant = 1'b1
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [5:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    input wire logic [7:0] porta_pin,
    input wire logic [7:0] portb_pin,
    input wire logic [7:0] portc_pin,
    output logic change_irq_request,
    output logic wake_request
);
    localparam logic [7:0] portc_mask = large_variant ?
        pin_change_pkg::portc_large_mask : pin_change_pkg::portc_small_mask;
    localparam logic [7:0] portb_mask = large_variant ?
        pin_change_pkg::portb_mask : pin_change_pkg::reg_reset;
    logic [7:0] mask [pin_change_pkg::num_ports];
    assign mask[0] = pin_change_pkg::porta_mask;
    assign mask[1] = portb_mask;
    assign mask[2] = portc_mask;

    logic [7:0] pins [pin_change_pkg::num_ports];
    assign pins[0] = porta_pin;
    assign pins[1] = portb_pin;
    assign pins[2] = portc_pin;

    logic [7:0] rise_en [pin_change_pkg::num_ports];
    logic [7:0] fall_en [pin_change_pkg::num_ports];
    logic [7:0] flags [pin_change_pkg::num_ports];
    logic [7:0] sync1 [pin_change_pkg::num_ports];
    logic [7:0] sync2 [pin_change_pkg::num_ports];
    logic [7:0] prev [pin_change_pkg::num_ports];
    logic [7:0] event_pulse [pin_change_pkg::num_ports];
    logic master_enable;
    pin_change_pkg::bus_state_t state;

    // bus decode
    wire logic [3:0] reg_index = wb_adr_i[5:2];
    wire logic access = wb_cyc_i && wb_stb_i && state == pin_change_pkg::bus_idle;
    wire logic do_write = access && wb_we_i && wb_sel_i[0];
    wire logic mapped = reg_index <= pin_change_pkg::addr_irq_control;
    wire logic [7:0] wdata = wb_dat_i[7:0];
    wire logic ctl_write = do_write && reg_index == pin_change_pkg::addr_irq_control;

    genvar p;
    generate
        for (p = 0; p < pin_change_pkg::num_ports; p++) begin : g_port
            localparam logic [3:0] base = 4'(3 * p);
            wire logic wr_rise = do_write && reg_index == base;
            wire logic wr_fall = do_write && reg_index == base + 4'h1;
            wire logic wr_flag = do_write && reg_index == base + 4'h2;
            // rising where prev low and now high, falling the reverse
            assign event_pulse[p] = ((sync2[p] & ~prev[p] & rise_en[p]) |
                (~sync2[p] & prev[p] & fall_en[p])) & mask[p];
            always_ff @(posedge core_clk) begin
                // first stage feeds only the second
                sync1[p] <= pins[p];
                sync2[p] <= sync1[p];
                prev[p] <= sync2[p];
                if (reset) begin
                    rise_en[p] <= pin_change_pkg::reg_reset;
                    fall_en[p] <= pin_change_pkg::reg_reset;
                    flags[p] <= pin_change_pkg::reg_reset;
                end else begin
                    if (wr_rise) begin
                        rise_en[p] <= wdata & mask[p];
                    end
                    if (wr_fall) begin
                        fall_en[p] <= wdata & mask[p];
                    end
                    // new events win over a software clear
                    if (wr_flag) begin
                        flags[p] <= ((wdata & mask[p]) | event_pulse[p]);
                    end else begin
                        flags[p] <= flags[p] | event_pulse[p];
                    end
                end
            end
        end
    endgenerate

    wire logic summary = (|flags[0]) | (|flags[1]) | (|flags[2]);

    logic [7:0] read_byte;
    always_comb begin
        read_byte = pin_change_pkg::reg_reset;
        case (reg_index)
            pin_change_pkg::addr_porta_rise: read_byte = rise_en[0];
            pin_change_pkg::addr_porta_fall: read_byte = fall_en[0];
            pin_change_pkg::addr_porta_flags: read_byte = flags[0];
            pin_change_pkg::addr_portb_rise: read_byte = rise_en[1];
            pin_change_pkg::addr_portb_fall: read_byte = fall_en[1];
            pin_change_pkg::addr_portb_flags: read_byte = flags[1];
            pin_change_pkg::addr_portc_rise: read_byte = rise_en[2];
            pin_change_pkg::addr_portc_fall: read_byte = fall_en[2];
            pin_change_pkg::addr_portc_flags: read_byte = flags[2];
            pin_change_pkg::addr_irq_control: begin
                read_byte[pin_change_pkg::irq_enable_bit] = master_enable;
                read_byte[pin_change_pkg::irq_summary_bit] = summary;
            end
            default: read_byte = pin_change_pkg::reg_reset;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            state <= pin_change_pkg::bus_idle;
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            master_enable <= 1'b0;
            change_irq_request <= 1'b0;
            wake_request <= 1'b0;
        end else begin
            case (state)
                pin_change_pkg::bus_idle: begin
                    wb_ack_o <= access && mapped;
                    wb_err_o <= access && !mapped;
                    wb_dat_o <= {24'h00_0000, read_byte};
                    if (access) begin
                        state <= pin_change_pkg::bus_ack;
                    end
                end
                pin_change_pkg::bus_ack: begin
                    wb_ack_o <= 1'b0;
                    wb_err_o <= 1'b0;
                    state <= pin_change_pkg::bus_idle;
                end
                default: state <= pin_change_pkg::bus_idle;
            endcase
            if (ctl_write) begin
                master_enable <= wdata[pin_change_pkg::irq_enable_bit];
            end
            // flags keep collecting while masked; only the irq and wake requests are gated
            change_irq_request <= master_enable && summary;
            wake_request <= master_enable && summary;
        end
    end

    property p_flag_set_a;
        @(posedge core_clk) disable iff (reset)
        (event_pulse[0] != 8'h00) |=>
            ((flags[0] & $past(event_pulse[0])) == $past(event_pulse[0]));
    endproperty
    a_flag_set_a: assert property (p_flag_set_a) else $error("port a flag missed event");

    property p_no_enable;
        @(posedge core_clk) disable iff (reset)
        (rise_en[2] == 8'h00 && fall_en[2] == 8'h00) |-> (event_pulse[2] == 8'h00);
    endproperty
    a_no_enable: assert property (p_no_enable) else $error("event without enable");

    property p_a_high_zero;
        @(posedge core_clk) disable iff (reset)
        (flags[0][7:6] == 2'b00 && rise_en[0][7:6] == 2'b00);
    endproperty
    a_a_high_zero: assert property (p_a_high_zero) else $error("port a high bits set");

    property p_b_low_zero;
        @(posedge core_clk) disable iff (reset)
        (flags[1][3:0] == 4'h0 && fall_en[1][3:0] == 4'h0);
    endproperty
    a_b_low_zero: assert property (p_b_low_zero) else $error("port b low bits set");

    property p_sticky;
        @(posedge core_clk) disable iff (reset)
        // a write taken at either edge may legally change the flags two edges on
        (flags[2] != 8'h00 && !do_write) ##1 !do_write |=>
            ((flags[2] & $past(flags[2], 2)) == $past(flags[2], 2));
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag lost without write");

    property p_set_wins;
        @(posedge core_clk) disable iff (reset)
        (do_write && reg_index == pin_change_pkg::addr_portc_flags && event_pulse[2] != 8'h00)
        |=> ((flags[2] & $past(event_pulse[2])) == $past(event_pulse[2]));
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("clear beat edge");

    property p_irq_gate;
        @(posedge core_clk) disable iff (reset)
        !master_enable ##1 !master_enable |-> !change_irq_request;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("request while disabled");

    property p_irq_follow;
        @(posedge core_clk) disable iff (reset)
        (master_enable && summary) |=> change_irq_request && wake_request;
    endproperty
    a_irq_follow: assert property (p_irq_follow) else $error("request missing");

    property p_reset_clear;
        @(posedge core_clk) reset |=> (flags[0] == 8'h00 && rise_en[1] == 8'h00 && !master_enable);
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("reset left state");

    property p_ack_once;
        @(posedge core_clk) disable iff (reset) wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack held");

    property p_flag_set_b;
        @(posedge core_clk) disable iff (reset)
        (event_pulse[1] != 8'h00) |=>
            ((flags[1] & $past(event_pulse[1])) == $past(event_pulse[1]));
    endproperty
    a_flag_set_b: assert property (p_flag_set_b) else $error("port b flag missed event");

    property p_flag_set_c;
        @(posedge core_clk) disable iff (reset)
        (event_pulse[2] != 8'h00) |=>
            ((flags[2] & $past(event_pulse[2])) == $past(event_pulse[2]));
    endproperty
    a_flag_set_c: assert property (p_flag_set_c) else $error("port c flag missed event");

    property p_rise_seen;
        @(posedge core_clk) disable iff (reset)
        ($rose(sync2[0][0]) && rise_en[0][0]) |-> event_pulse[0][0];
    endproperty
    a_rise_seen: assert property (p_rise_seen) else $error("rising edge not seen");

    property p_fall_seen;
        @(posedge core_clk) disable iff (reset)
        ($fell(sync2[2][7]) && fall_en[2][7] && portc_mask[7]) |-> event_pulse[2][7];
    endproperty
    a_fall_seen: assert property (p_fall_seen) else $error("falling edge not seen");

    property p_event_edge;
        @(posedge core_clk) disable iff (reset)
        (event_pulse[1] != 8'h00) |-> ((sync2[1] ^ prev[1]) != 8'h00);
    endproperty
    a_event_edge: assert property (p_event_edge) else $error("event without edge");

    property p_summary_set;
        @(posedge core_clk) disable iff (reset)
        (event_pulse[2] != 8'h00) |=> summary;
    endproperty
    a_summary_set: assert property (p_summary_set) else $error("summary not raised");

    property p_clear_takes;
        @(posedge core_clk) disable iff (reset)
        (do_write && reg_index == pin_change_pkg::addr_porta_flags && event_pulse[0] == 8'h00)
            |=> (flags[0] == ($past(wdata) & pin_change_pkg::porta_mask));
    endproperty
    a_clear_takes: assert property (p_clear_takes) else $error("flag write not applied");

    property p_b_rise_zero;
        @(posedge core_clk) disable iff (reset)
        ((rise_en[1] & ~portb_mask) == 8'h00);
    endproperty
    a_b_rise_zero: assert property (p_b_rise_zero) else $error("port b rise bits set");

    property p_wake_gate;
        @(posedge core_clk) disable iff (reset)
        !master_enable ##1 !master_enable |-> !wake_request;
    endproperty
    a_wake_gate: assert property (p_wake_gate) else $error("wake while disabled");

    property p_answer_once;
        @(posedge core_clk) disable iff (reset)
        (wb_cyc_i && wb_stb_i && state == pin_change_pkg::bus_idle)
            |=> (wb_ack_o ^ wb_err_o);
    endproperty
    a_answer_once: assert property (p_answer_once) else $error("no single answer");

    property p_err_data;
        @(posedge core_clk) disable iff (reset)
        wb_err_o |-> (wb_dat_o == 32'h0000_0000);
    endproperty
    a_err_data: assert property (p_err_data) else $error("error with data");

    property p_idle_quiet;
        @(posedge core_clk) disable iff (reset)
        !summary |=> !change_irq_request;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("request without flag");

    c_edge_a: cover property (@(posedge core_clk) event_pulse[0] != 8'h00);
    c_race: cover property (@(posedge core_clk) do_write && event_pulse[2] != 8'h00);
    c_irq: cover property (@(posedge core_clk) change_irq_request);
    c_err: cover property (@(posedge core_clk) wb_err_o);
    c_wake: cover property (@(posedge core_clk) wake_request);
endmodule
`default_nettype wire

// File: shared/pin_change_pkg.sv
package pin_change_pkg;
    localparam int unsigned core_clk_mhz = 250;
    localparam logic [3:0] addr_porta_rise = 4'h0;
    localparam logic [3:0] addr_porta_fall = 4'h1;
    localparam logic [3:0] addr_porta_flags = 4'h2;
    localparam logic [3:0] addr_portb_rise = 4'h3;
    localparam logic [3:0] addr_portb_fall = 4'h4;
    localparam logic [3:0] addr_portb_flags = 4'h5;
    localparam logic [3:0] addr_portc_rise = 4'h6;
    localparam logic [3:0] addr_portc_fall = 4'h7;
    localparam logic [3:0] addr_portc_flags = 4'h8;
    localparam logic [3:0] addr_irq_control = 4'h9;
    localparam int unsigned addr_lsb = 2;
    localparam logic [7:0] porta_mask = 8'h3f;
    localparam logic [7:0] portb_mask = 8'hf0;
    localparam logic [7:0] portc_small_mask = 8'h3f;
    localparam logic [7:0] portc_large_mask = 8'hff;
    localparam logic [7:0] reg_reset = 8'h00;
    localparam int unsigned irq_enable_bit = 0;
    localparam int unsigned irq_summary_bit = 1;
    localparam int unsigned num_ports = 3;
    typedef enum logic [0:0] {
        bus_idle = 1'b0,
        bus_ack = 1'b1
    } bus_state_t;
endpackage

// File: verif/pin_driver.sv
`timescale 1ns/1ps
`default_nettype none
module pin_driver (
    input wire logic core_clk,
    input wire logic [23:0] level,
    output logic [7:0] porta_pin,
    output logic [7:0] portb_pin,
    output logic [7:0] portc_pin
);
    // pins move only just after an edge, like a synchronous source
    always_ff @(posedge core_clk) begin
        {portc_pin, portb_pin, porta_pin} <= level;
    end
endmodule
`default_nettype wire

// File: verif/pin_change_edge_detector_test.sv
`timescale 1ns/1ps
`default_nettype none
module pin_change_edge_detector_test;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [3:0] sel = 4'h1;
    logic [5:0] adr = 6'h00;
    logic [31:0] wdat = 32'h00000000;
    logic [31:0] rdat;
    logic ack;
    logic err;
    logic irq;
    logic wake;
    logic berr;
    logic [23:0] lvl = 24'h000000;
    logic [7:0] pa;
    logic [7:0] pb;
    logic [7:0] pc;
    logic [31:0] q;
    int num_errors = 0;
    int tests_run = 0;
    always #2 core_clk = ~core_clk;
    pin_driver i_pins (.core_clk(core_clk), .level(lvl), .porta_pin(pa), .portb_pin(pb),
        .portc_pin(pc));
    pin_change_edge_detector #(.large_variant(1'b1)) i_dut (.core_clk(core_clk),
        .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err),
        .porta_pin(pa), .portb_pin(pb), .portc_pin(pc), .change_irq_request(irq),
        .wake_request(wake));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // waits for ack or err; only the watchdog ends a wait on a dead slave
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {a, 2'b00};
        wdat <= {24'h000000, d};
        do begin
            @(posedge core_clk);
        end while (ack !== 1'b1 && err !== 1'b1);
        q = rdat;
        berr = err;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        bus(1'b0, a, 8'h00);
        chk(q, exp);
    endtask
    task automatic t_reset();
        for (int i = 0; i < 10; i++) rd(4'(i), 32'h00000000);
        bus(1'b0, 4'ha, 8'h00);
        chk({31'h0, berr}, 32'h00000001);
        chk({31'h0, irq}, 32'h00000000);
    endtask
    task automatic t_masks();
        logic [3:0] idx [9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8};
        logic [7:0] msk [9] = '{8'h3f, 8'h3f, 8'h3f, 8'hf0, 8'hf0, 8'hf0, 8'hff, 8'hff, 8'hff};
        for (int i = 0; i < 9; i++) begin
            bus(1'b1, idx[i], 8'hff);
            rd(idx[i], {24'h0, msk[i]});
            bus(1'b1, idx[i], 8'h00);
        end
        // a write without its byte lane is acknowledged but ignored
        sel <= 4'h0;
        bus(1'b1, 4'h0, 8'h3f);
        sel <= 4'h1;
        rd(4'h0, 32'h00000000);
    endtask
    task automatic t_race();
        bus(1'b1, 4'h6, 8'h01);
        bus(1'b1, 4'h8, 8'h02);
        rd(4'h8, 32'h00000002);
        // pin stage plus two sync stages put the event in the clear's cycle
        lvl <= 24'h010000;
        repeat (3) @(posedge core_clk);
        bus(1'b1, 4'h8, 8'h00);
        rd(4'h8, 32'h00000001);
        bus(1'b1, 4'h8, 8'h00);
        rd(4'h8, 32'h00000000);
        bus(1'b1, 4'h6, 8'h00);
        lvl <= 24'h000000;
    endtask
    task automatic t_reset_mid();
        bus(1'b1, 4'h2, 8'h01);
        bus(1'b1, 4'h0, 8'h3f);
        repeat (2) @(posedge core_clk);
        chk({31'h0, irq}, 32'h00000001);
        reset <= 1'b1;
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        chk({31'h0, irq}, 32'h00000000);
        for (int i = 0; i < 10; i++) rd(4'(i), 32'h00000000);
        chk({31'h0, wake}, 32'h00000000);
    endtask
    task automatic t_rise();
        bus(1'b1, 4'h0, 8'h3f);
        lvl <= 24'h000001;
        repeat (6) @(posedge core_clk);
        rd(4'h2, 32'h00000001);
        rd(4'h9, 32'h00000002);
        chk({31'h0, irq}, 32'h00000000);
        lvl <= 24'h000000;
        repeat (6) @(posedge core_clk);
        rd(4'h2, 32'h00000001);
        bus(1'b1, 4'h2, 8'h00);
        rd(4'h2, 32'h00000000);
        bus(1'b1, 4'h0, 8'h00);
    endtask
    task automatic t_fall();
        bus(1'b1, 4'h4, 8'hf0);
        bus(1'b1, 4'h7, 8'h80);
        lvl <= 24'h808000;
        repeat (6) @(posedge core_clk);
        rd(4'h5, 32'h00000000);
        rd(4'h8, 32'h00000000);
        lvl <= 24'h000000;
        repeat (6) @(posedge core_clk);
        rd(4'h5, 32'h00000080);
        rd(4'h8, 32'h00000080);
        bus(1'b1, 4'h9, 8'h01);
        repeat (2) @(posedge core_clk);
        chk({31'h0, irq}, 32'h00000001);
        chk({31'h0, wake}, 32'h00000001);
        bus(1'b1, 4'h5, 8'h00);
        bus(1'b1, 4'h8, 8'h00);
        repeat (2) @(posedge core_clk);
        chk({31'h0, irq}, 32'h00000000);
        rd(4'h9, 32'h00000001);
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        #20000;
        num_errors++;
        end_of_test();
    end
    initial begin
        repeat (8) @(posedge core_clk);
        reset <= 1'b0;
        repeat (3) @(posedge core_clk);
        t_reset();
        t_masks();
        t_rise();
        t_race();
        t_fall();
        t_reset_mid();
        end_of_test();
    end
endmodule
`default_nettype wire
